// ---- hdl/btmr_top.sv ----
// Purpose: 14-bit periodic timer with buzzer, AXI4-Lite registers
// Assumes: clock sources arrive as levels from other domains
// Notes: outputs all come from flip-flops
// Function
// - clock select field picks count source
// - 8-bit stage overflow clocks 6-bit stage
// - fast bit feeds high stage directly
// - fast mode: irq0 every 64 counts
// - normal mode: irq0 every 16384 counts
// - run bit clear stops at zero count
// - period field selects irq1 period
// - irq1 flag sticky until software clears
// - irq0 flag sticky until software clears
// - enabled irq1 raises request and release
// - enabled irq0 raises request and release
// - buzzer enabled outputs count clock over 16
// - buzzer disabled passes timer 1 PWM straight to the output
// - buzzer ANDed with timer 1 PWM
// - software may clear the whole chain
// - hold mode counting needs power bit
// - period field rewrite may set irq1
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module btmr_top
  import btmr_pkg::*;
#(
  parameter int LOW_W = 8,
  parameter int HIGH_W = 6
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [btmr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [btmr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Count clock sources, asynchronous levels
  input wire logic subclock,
  input wire logic cycle_clock,
  input wire logic t0_prescale,
  // Power state, same clock domain
  input wire logic hold_mode,
  input wire logic power_control_hold_run,
  // Timer 1 PWM, same clock domain
  input wire logic timer1_high_pwm,
  // Outputs
  output logic irq_req,
  output logic hold_release,
  output logic buzzer_port_pin
);
  import btmr_pkg::*;

  localparam int CW = LOW_W + HIGH_W;

  btmr_ctrl_t ctrl_q;
  btmr_isl_t isl_q;
  logic [LOW_W-1:0] low_q;
  logic [HIGH_W-1:0] high_q;
  logic [CW-1:0] chain;
  logic [2:0] src_rise;
  logic sel_rise;
  logic running;
  logic tick;
  logic low_ovf;
  logic high_inc;
  logic irq0_hit;
  logic irq1_hit;
  logic [13:0] irq1_mask;
  logic [1:0] sel;

  // Bus side state
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;
  logic wr_ctrl;
  logic wr_isl;
  logic wr_cnt;
  logic wr_lane0;
  logic [15:0] aw_idx;
  logic [15:0] ar_idx;
  logic wr_ctrl_en;
  logic wr_isl_en;
  logic wr_cnt_en;
  logic irq1_pend;
  logic irq0_pend;
  logic [31:0] rd_word;
  logic rd_err;

  assign chain = {high_q, low_q};

  // Each count source gets its own synchroniser and edge detector
  btmr_edge_sync u_btmr_edge_sync_sub (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(subclock),
    .rise(src_rise[0])
  );

  btmr_edge_sync u_btmr_edge_sync_cyc (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(cycle_clock),
    .rise(src_rise[1])
  );

  btmr_edge_sync u_btmr_edge_sync_t0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(t0_prescale),
    .rise(src_rise[2])
  );

  assign sel = {isl_q.count_clock_sel_hi, isl_q.count_clock_sel_lo};

  always_comb begin
    case (sel)
      SRC_CYCLE: sel_rise = src_rise[1];
      SRC_T0: sel_rise = src_rise[2];
      default: sel_rise = src_rise[0];
    endcase
  end

  // Stopped state is only left through the run bit
  assign running = ctrl_q.run_continue || (chain != '0);
  // Hold mode freezes the chain unless the power bit lets it run
  assign tick = sel_rise && running
    && !(hold_mode && !power_control_hold_run);
  assign low_ovf = tick && (&low_q);
  assign high_inc = ctrl_q.fast_period_select ? tick : low_ovf;

  always_comb begin
    irq0_hit = tick && (&chain);
    if (ctrl_q.fast_period_select) begin
      irq0_hit = tick && (&high_q);
    end
  end

  always_comb begin
    case ({ctrl_q.irq1_period_hi, ctrl_q.irq1_period_lo})
      2'h0: irq1_mask = IRQ1_M32;
      2'h1: irq1_mask = IRQ1_M128;
      2'h2: begin
        irq1_mask = ctrl_q.fast_period_select ? IRQ1_MF2 : IRQ1_M512;
      end
      default: begin
        irq1_mask = ctrl_q.fast_period_select ? IRQ1_MF8 : IRQ1_M2048;
      end
    endcase
  end

  // Field rewrite can land on an all-ones pattern and fire early
  assign irq1_hit = tick
    && ((chain[13:0] & irq1_mask) == irq1_mask);

  // Counter stages; a clear wins over a tick in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_q <= '0;
      high_q <= '0;
    end else if (wr_cnt_en) begin
      low_q <= '0;
      high_q <= '0;
    end else begin
      if (tick) begin
        low_q <= low_q + 1'b1;
      end
      if (high_inc) begin
        high_q <= high_q + 1'b1;
      end
    end
  end

  // Write decode
  assign aw_idx = aw_addr_q[ADDR_W-1:2];
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_lane0 = w_strb_q[0];
  assign wr_ctrl = (aw_idx == CTRL_IDX);
  assign wr_isl = (aw_idx == ISL_IDX);
  assign wr_cnt = (aw_idx == CNT_IDX);
  // Counter clear ignores the strobes; the byte registers need lane 0
  assign wr_ctrl_en = wr_go && wr_ctrl && wr_lane0;
  assign wr_isl_en = wr_go && wr_isl && wr_lane0;
  assign wr_cnt_en = wr_go && wr_cnt;

  // Control register; hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_ctrl_en) begin
        ctrl_q <= btmr_ctrl_t'(w_data_q[7:0]);
      end
      if (irq1_hit) begin
        ctrl_q.irq1_flag <= 1'b1;
      end
      if (irq0_hit) begin
        ctrl_q.irq0_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      isl_q <= ISL_RST;
    end else if (wr_isl_en) begin
      isl_q <= btmr_isl_t'(w_data_q[7:0]);
    end
  end

  // Both sources share one vector and one release line
  assign irq1_pend = ctrl_q.irq1_enable && ctrl_q.irq1_flag;
  assign irq0_pend = ctrl_q.irq0_enable && ctrl_q.irq0_flag;

  // Request and hold release share one vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= 1'b0;
      hold_release <= 1'b0;
    end else begin
      irq_req <= irq1_pend || irq0_pend;
      hold_release <= irq1_pend || irq0_pend;
    end
  end

  // Buzzer; idle level high so the AND passes the PWM through
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buzzer_port_pin <= 1'b0;
    end else if (isl_q.buzzer_enable) begin
      buzzer_port_pin <= low_q[BUZ_BIT] & timer1_high_pwm;
    end else begin
      buzzer_port_pin <= timer1_high_pwm;
    end
  end

  // Write address and data are taken independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_ctrl || wr_isl || wr_cnt) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data is chosen from the address as it is offered
  always_comb begin
    rd_word = 32'h00000000;
    rd_err = 1'b0;
    case (ar_idx)
      CTRL_IDX: rd_word = {24'h000000, ctrl_q};
      ISL_IDX: rd_word = {24'h000000, isl_q};
      CNT_IDX: rd_word = {{(32-CW){1'b0}}, chain};
      default: rd_err = 1'b1;
    endcase
  end

  // Read channel; one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // btmr_top

// Two-flop synchroniser with a third flop used only for edge detection
module btmr_edge_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous level in, one-cycle rise pulse out
  input wire logic async_in,
  output logic rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // Only sync_q reads meta_q, so nothing sees a metastable value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // A source sitting high at reset release counts once
  assign rise = sync_q && !last_q;

endmodule // btmr_edge_sync

// ---- inc/btmr_pkg.sv ----
// Purpose: shared constants and types of the 14-bit periodic timer
// Assumes: 32-bit AXI4-Lite, registers addressed by word index
// Notes: byte address of a register is four times its index
package btmr_pkg;

  // Register word indices and byte address width
  localparam int ADDR_W = 18;
  localparam logic [15:0] CTRL_IDX = 16'hFE7F;
  localparam logic [15:0] ISL_IDX = 16'hFE5F;
  localparam logic [15:0] CNT_IDX = 16'hFE80;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ISL_RST = 8'h00;

  // Count clock source codes; any other code picks the subclock
  localparam logic [1:0] SRC_CYCLE = 2'h1;
  localparam logic [1:0] SRC_T0 = 2'h3;

  // Chain bit that toggles every 8 count clocks (buzzer = count_clock_freq/16)
  localparam int BUZ_BIT = 3;

  // Chain masks whose all-ones state ends one interrupt 1 period
  localparam logic [13:0] IRQ1_M32 = 14'h001F;
  localparam logic [13:0] IRQ1_M128 = 14'h007F;
  localparam logic [13:0] IRQ1_M512 = 14'h01FF;
  localparam logic [13:0] IRQ1_M2048 = 14'h07FF;
  localparam logic [13:0] IRQ1_MF2 = 14'h0100;
  localparam logic [13:0] IRQ1_MF8 = 14'h0700;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic fast_period_select;
    logic run_continue;
    logic irq1_period_hi;
    logic irq1_period_lo;
    logic irq1_flag;
    logic irq1_enable;
    logic irq0_flag;
    logic irq0_enable;
  } btmr_ctrl_t;

  typedef struct packed {
    logic [1:0] capture_sel;
    logic count_clock_sel_hi;
    logic count_clock_sel_lo;
    logic buzzer_enable;
    logic [2:0] filter_sel;
  } btmr_isl_t;

endpackage

// ---- testbench/btmr_sva.sv ----
// Purpose: port-level checks for btmr_top
// Assumes: one clock, registered outputs
// Notes: flags are internal, so only their effects are watched
`timescale 1ns/1ps
module btmr_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Timer side
  input wire logic timer1_high_pwm,
  input wire logic irq_req,
  input wire logic hold_release,
  input wire logic buzzer_port_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  same_req_a: assert property (irq_req == hold_release)
    else $error("request and release differ");
  pwm_gate_a: assert property (!timer1_high_pwm |=>
    !buzzer_port_pin) else $error("pin high while pwm low");
  // Only a register write may take a pending request away
  flag_sticky_a: assert property ($fell(irq_req) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) ||
    $past(s_axi_bvalid, 3)) else $error("request fell with no write");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("bvalid dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |->
    ##[1:2] s_axi_rvalid) else $error("no read response");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("ready during bvalid");
  cover property ($rose(irq_req));
  cover property ($rose(buzzer_port_pin));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // btmr_sva
bind btmr_top btmr_sva u_btmr_sva (.*);

// ---- testbench/btmr_top_tb_top.sv ----
// Purpose: register-level bench for btmr_top
// Assumes: count sources are pulsed by the bench
// Notes: each tick is one cycle high, one low, so the synchroniser sees it
`timescale 1ns/1ps
module btmr_top_tb_top;
  import btmr_pkg::*;
  localparam logic [17:0] AC = {CTRL_IDX, 2'h0};
  localparam logic [17:0] AI = {ISL_IDX, 2'h0};
  localparam logic [17:0] AN = {CNT_IDX, 2'h0};
  logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0;
  logic arv = 1'h0, rr = 1'h0, pwm = 1'h1, hm = 1'h0, pc = 1'h0;
  logic [2:0] src = 3'h0;
  logic [17:0] awa = 18'h0, ara = 18'h0;
  logic [31:0] wd = 32'h0, rdata, got, cv;
  logic [1:0] bresp, rresp, resp;
  logic awr, wrd, bv, arr, rv, irq, hr, buz;
  int n_errors = 0, total_checks = 0;
  int pr [8] = '{32, 128, 512, 2048, 32, 128, 2, 8};
  btmr_top u_btmr_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .subclock(src[0]), .cycle_clock(src[1]),
    .t0_prescale(src[2]), .hold_mode(hm), .power_control_hold_run(pc),
    .timer1_high_pwm(pwm), .irq_req(irq), .hold_release(hr),
    .buzzer_port_pin(buz));
  initial forever #20 aclk = ~aclk;
  task automatic chk(input string s, input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; br <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
      if (bv) begin
        resp = bresp;
        br <= 1'h0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [17:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1'h1; rr <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
      if (rv) begin
        got = rdata;
        resp = rresp;
        rr <= 1'h0;
        break;
      end
    end
  endtask
  task automatic tk(input logic [2:0] w, input int n);
    repeat (n) begin
      @(posedge aclk) src <= w;
      @(posedge aclk) src <= 3'h0;
    end
    repeat (6) @(posedge aclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(AC); chk("ctrl", got, {24'h0, CTRL_RST});
    rd(AI); chk("isl", got, {24'h0, ISL_RST});
    rd(18'h0); chk("bad rd", {got[29:0], resp}, {30'h0, RESP_SLVERR});
    wr(18'h0, 32'hFF); chk("bad wr", resp, RESP_SLVERR);
    wr(AC, 32'h40);
    // Each source gets its own pulse count
    for (int c = 0; c < 4; c++) begin
      wr(AI, 32'(c << 4)); wr(AN, 32'h0);
      tk(3'h1, 2); tk(3'h2, 3); tk(3'h4, 5);
      rd(AN); chk("src", got, c == 1 ? 3 : c == 3 ? 5 : 2);
    end
    wr(AI, 32'h18); wr(AC, 32'h0); wr(AN, 32'h0); tk(3'h2, 3);
    rd(AN); chk("stop", got, 0);
    wr(AC, 32'h40); wr(AI, 32'h38); hm <= 1'h1; tk(3'h4, 3);
    rd(AN); chk("hold", got, 0);
    pc <= 1'h1; tk(3'h4, 3);
    rd(AN); chk("hold run", got, 3);
    hm <= 1'h0; wr(AI, 32'h18); chk("buz", buz, 0);
    tk(3'h2, 5); chk("buz", buz, 1);
    tk(3'h2, 8); chk("buz", buz, 0);
    wr(AI, 32'h10); repeat (3) @(posedge aclk);
    chk("buz off", buz, 1);
    wr(AI, 32'h18); tk(3'h2, 8); pwm <= 1'h0; repeat (3) @(posedge aclk);
    chk("buz pwm", buz, 0);
    pwm <= 1'h1; wr(AN, 32'h0); wr(AC, 32'hC1); tk(3'h2, 64);
    rd(AC); chk("fast", got, 32'hCB);
    chk("irq0", {irq, hr}, 2'h3);
    wr(AC, 32'hC4); repeat (3) @(posedge aclk);
    chk("irq clr", irq, 0);
    tk(3'h2, 32); chk("irq1", {irq, hr}, 2'h3);
    // Second control write drops any flag raised by the period change
    for (int i = 0; i < 8; i++) begin
      cv = {24'h0, i[2], 1'h1, i[1:0], 4'h0};
      wr(AC, cv); wr(AN, 32'h0); wr(AC, cv);
      tk(3'h2, pr[i] - 1); rd(AC); chk("early", got[3], 0);
      tk(3'h2, 1); rd(AC); chk("period", got[3], 1);
    end
    wr(AC, 32'h41); wr(AN, 32'h0); wr(AC, 32'h41);
    tk(3'h2, 16383); rd(AC); chk("early0", got[1], 0);
    tk(3'h2, 1); rd(AC); chk("irq0 norm", got[1], 1);
    wrap_up();
  end
endmodule // btmr_top_tb_top
